// [pkg/rbt_pkg.sv]
// Constants, field layouts and carrier types for the registered bus transceiver.
// Assumes one 10 MHz clock, synchronous active-low reset and an AXI4-Lite master.
// Function
// - Each storage register loads its own bus on its capture clock's rising edge.
// - Capture happens on every rising edge, whatever enable and direction are.
// - Output enable high releases both buses; capture still goes on.
// - When enabled, direction low drives A, direction high drives B.
// - Direction low, B-to-A select low: A bus follows live B bus.
// - Direction low, B-to-A select high: A bus shows B-side register.
// - Direction high, A-to-B select low: B bus follows live A bus.
// - Direction high, A-to-B select high: B bus shows A-side register.
// - B-side register appears only on A pins, A-side register only on B pins.
// - The input bus may be stored in either or both registers by pulsing clocks.
// - Each source select affects only its own direction's output path.
// - Buses and registers are eight bits wide, identical logic per bit.
package rbt_pkg;

  localparam int RBT_BUS_W      = 8;
  localparam int RBT_AXI_AW     = 6;
  localparam int RBT_AXI_DW     = 32;
  localparam int RBT_LOG_DEPTH  = 4;
  localparam int RBT_LOG_W      = 2 * RBT_BUS_W + 2;

  // Register byte offsets
  localparam logic [RBT_AXI_AW-1:0] RBT_ADDR_CTRL  = 6'h00;
  localparam logic [RBT_AXI_AW-1:0] RBT_ADDR_STORE = 6'h04;
  localparam logic [RBT_AXI_AW-1:0] RBT_ADDR_LIVE  = 6'h08;
  localparam logic [RBT_AXI_AW-1:0] RBT_ADDR_LOG   = 6'h0C;

  // Register indices after decode
  localparam logic [1:0] RBT_IDX_CTRL  = 2'h0;
  localparam logic [1:0] RBT_IDX_STORE = 2'h1;
  localparam logic [1:0] RBT_IDX_LIVE  = 2'h2;
  localparam logic [1:0] RBT_IDX_LOG   = 2'h3;

  // Field positions
  localparam int RBT_CTRL_OE_N_BIT     = 0;
  localparam int RBT_CTRL_DIR_BIT      = 1;
  localparam int RBT_CTRL_AB_SEL_BIT   = 2;
  localparam int RBT_CTRL_BA_SEL_BIT   = 3;
  localparam int RBT_STORE_A_LSB       = 0;
  localparam int RBT_STORE_B_LSB       = 8;
  localparam int RBT_STORE_A_VALID_BIT = 16;
  localparam int RBT_STORE_B_VALID_BIT = 17;
  localparam int RBT_LIVE_A_LSB        = 0;
  localparam int RBT_LIVE_B_LSB        = 8;
  localparam int RBT_LIVE_A_DRV_BIT    = 16;
  localparam int RBT_LIVE_B_DRV_BIT    = 17;
  localparam int RBT_LOG_A_LSB         = 0;
  localparam int RBT_LOG_B_LSB         = 8;
  localparam int RBT_LOG_A_CAP_BIT     = 16;
  localparam int RBT_LOG_B_CAP_BIT     = 17;
  localparam int RBT_LOG_OVF_BIT       = 30;
  localparam int RBT_LOG_VALID_BIT     = 31;

  // AXI responses
  localparam logic [1:0] RBT_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RBT_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic b_to_a_source_sel;
    logic a_to_b_source_sel;
    logic dir;
    logic output_enable_n;
  } rbt_ctrl_t;

  // Isolation after reset: both buses released
  localparam rbt_ctrl_t RBT_CTRL_RESET = 4'h1;

  typedef struct packed {
    logic [RBT_BUS_W-1:0] oe;
    logic [RBT_BUS_W-1:0] data;
  } rbt_drive_t;

  typedef struct packed {
    logic                 b_cap;
    logic                 a_cap;
    logic [RBT_BUS_W-1:0] b_data;
    logic [RBT_BUS_W-1:0] a_data;
  } rbt_log_t;

  typedef struct packed {
    rbt_ctrl_t             ctrl;
    logic [RBT_BUS_W-1:0]  a_store;
    logic [RBT_BUS_W-1:0]  b_store;
    logic                  a_loaded;
    logic                  b_loaded;
    logic                  a_clk_prev;
    logic                  b_clk_prev;
    logic                  log_overflow;
    logic                  aw_got;
    logic                  w_got;
    logic [RBT_AXI_AW-1:0] awaddr;
    logic [RBT_AXI_DW-1:0] wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [RBT_AXI_DW-1:0] rdata;
    logic [1:0]            rresp;
  } rbt_core_st_t;

endpackage

// [hw/rbt_fifo.sv]
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset; contents are not reset.
module rbt_fifo
  import rbt_pkg::*;
#(
  parameter int WIDTH = RBT_LOG_W,
  parameter int DEPTH = RBT_LOG_DEPTH
)
(
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [PW:0]                 count;
  } rbt_fifo_st_t;

  rbt_fifo_st_t st_r;
  rbt_fifo_st_t st_nxt;
  logic         push;
  logic         pop;

  assign in_ready  = (st_r.count != (PW+1)'(DEPTH));
  assign out_valid = (st_r.count != '0);
  assign out_data  = st_r.mem[st_r.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wr_ptr] = in_data;
      st_nxt.wr_ptr = (st_r.wr_ptr == PW'(DEPTH - 1)) ? '0 : st_r.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      st_nxt.rd_ptr = (st_r.rd_ptr == PW'(DEPTH - 1)) ? '0 : st_r.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10:   st_nxt.count = st_r.count + 1'b1;
      2'b01:   st_nxt.count = st_r.count - 1'b1;
      default: st_nxt.count = st_r.count;
    endcase
    if (!aresetn)
    begin
      st_nxt.wr_ptr = '0;
      st_nxt.rd_ptr = '0;
      st_nxt.count  = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    st_r <= st_nxt;
  end

endmodule

// [hw/rbt_transceiver.sv]
// Eight-bit registered bus transceiver with AXI4-Lite control and a capture log.
// Assumes bus pins and capture clocks are synchronous to aclk; the bench resolves
// each bus wire from the data and enable outputs.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
module rbt_transceiver
  import rbt_pkg::*;
#(
  // Capture log entries
  parameter int LOG_DEPTH = RBT_LOG_DEPTH
)
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // A bus pins
  input  wire logic [RBT_BUS_W-1:0]  a_in,
  output rbt_drive_t                 a_drive,
  // B bus pins
  input  wire logic [RBT_BUS_W-1:0]  b_in,
  output rbt_drive_t                 b_drive,
  // Capture clocks, sampled as levels
  input  wire logic                  a_side_capture_clock,
  input  wire logic                  b_side_capture_clock,
  // Capture log room
  output logic                       capture_log_ready,
  // AXI4-Lite write address
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [RBT_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [RBT_AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // AXI4-Lite write response
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [RBT_AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  // AXI4-Lite read data
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [RBT_AXI_DW-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp
);

  rbt_core_st_t st_r;
  rbt_core_st_t st_nxt;

  logic     a_edge;
  logic     b_edge;
  logic     a_enabled;
  logic     b_enabled;
  logic     aw_hs;
  logic     w_hs;
  logic     ar_hs;
  logic     wr_fire;
  logic     log_push;
  logic     log_push_ready;
  rbt_log_t log_in;
  logic     log_valid;
  logic     log_pop;
  rbt_log_t log_out;
  logic [2:0] wr_dec;
  logic [2:0] rd_dec;

  // Returns {hit, index} for an aligned register byte address
  function automatic logic [2:0] reg_decode(input logic [RBT_AXI_AW-1:0] addr);
    logic hit;
    hit = (addr[RBT_AXI_AW-1:4] == '0) && (addr[1:0] == 2'h0);
    return {hit, addr[3:2]};
  endfunction

  // True when a decoded address names the given register
  function automatic logic reg_hit(input logic [2:0] dec, input logic [1:0] idx);
    return dec[2] && (dec[1:0] == idx);
  endfunction

  // A low level at one edge and a high level at the next mark a capture
  function automatic logic cap_rise(input logic now, input logic was);
    return now && !was;
  endfunction

  // Capture clocks are plain levels; a low-to-high change marks a capture
  assign a_edge = cap_rise(a_side_capture_clock, st_r.a_clk_prev);
  assign b_edge = cap_rise(b_side_capture_clock, st_r.b_clk_prev);

  // Direction and enable pick at most one driven bus
  assign a_enabled = !st_r.ctrl.output_enable_n && !st_r.ctrl.dir;
  assign b_enabled = !st_r.ctrl.output_enable_n && st_r.ctrl.dir;

  genvar gi;
  generate
    for (gi = 0; gi < RBT_BUS_W; gi++)
    begin : g_bit
      // A pins carry only live B or the B-side register
      assign a_drive.oe[gi]   = a_enabled;
      assign a_drive.data[gi] = st_r.ctrl.b_to_a_source_sel ? st_r.b_store[gi]
                                                            : b_in[gi];
      // B pins carry only live A or the A-side register
      assign b_drive.oe[gi]   = b_enabled;
      assign b_drive.data[gi] = st_r.ctrl.a_to_b_source_sel ? st_r.a_store[gi]
                                                            : a_in[gi];
    end
  endgenerate

  // Capture log: every capture is recorded while room remains
  assign log_in.a_cap  = a_edge;
  assign log_in.b_cap  = b_edge;
  assign log_in.a_data = a_in;
  assign log_in.b_data = b_in;
  assign log_push      = a_edge || b_edge;
  assign capture_log_ready = log_push_ready;

  rbt_fifo #(
    .WIDTH (RBT_LOG_W),
    .DEPTH (LOG_DEPTH)
  ) u_log (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (log_push),
    .in_ready  (log_push_ready),
    .in_data   (log_in),
    .out_valid (log_valid),
    .out_ready (log_pop),
    .out_data  (log_out)
  );

  // AXI4-Lite handshakes
  // A held answer blocks new requests: one write and one read at most are open
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;

  assign aw_hs   = s_axi_awvalid && s_axi_awready;
  assign w_hs    = s_axi_wvalid && s_axi_wready;
  assign ar_hs   = s_axi_arvalid && s_axi_arready;
  // The response waits until both address and data have been taken
  assign wr_fire = (st_r.aw_got || aw_hs) && (st_r.w_got || w_hs);
  assign wr_dec  = reg_decode(st_r.aw_got ? st_r.awaddr : s_axi_awaddr);
  assign rd_dec  = reg_decode(s_axi_araddr);

  // Reading the log register removes the entry it returns
  assign log_pop = ar_hs && reg_hit(rd_dec, RBT_IDX_LOG);

  always_comb
  begin
    logic [RBT_AXI_DW-1:0] wd;
    logic [3:0]            ws;
    logic [RBT_AXI_DW-1:0] rd;
    wd = st_r.w_got ? st_r.wdata : s_axi_wdata;
    ws = st_r.w_got ? st_r.wstrb : s_axi_wstrb;
    rd = '0;
    st_nxt = st_r;

    // Capture runs regardless of enable, direction or selects
    st_nxt.a_clk_prev = a_side_capture_clock;
    st_nxt.b_clk_prev = b_side_capture_clock;
    if (a_edge)
    begin
      st_nxt.a_store  = a_in;
      st_nxt.a_loaded = 1'b1;
    end
    if (b_edge)
    begin
      st_nxt.b_store  = b_in;
      st_nxt.b_loaded = 1'b1;
    end

    // Write channel: address and data taken in either order
    if (aw_hs)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (w_hs)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = wr_dec[2] ? RBT_RESP_OKAY : RBT_RESP_SLVERR;
      if (reg_hit(wr_dec, RBT_IDX_CTRL) && ws[0])
      begin
        // Each select is an independent bit of its own path
        st_nxt.ctrl.output_enable_n   = wd[RBT_CTRL_OE_N_BIT];
        st_nxt.ctrl.dir               = wd[RBT_CTRL_DIR_BIT];
        st_nxt.ctrl.a_to_b_source_sel = wd[RBT_CTRL_AB_SEL_BIT];
        st_nxt.ctrl.b_to_a_source_sel = wd[RBT_CTRL_BA_SEL_BIT];
      end
      if (reg_hit(wr_dec, RBT_IDX_LOG) && ws[3] && wd[RBT_LOG_OVF_BIT])
      begin
        st_nxt.log_overflow = 1'b0;
      end
    end
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end

    // A capture lost to a full log sets overflow; set beats clear
    if (log_push && !log_push_ready)
    begin
      st_nxt.log_overflow = 1'b1;
    end

    // Read channel
    if (ar_hs)
    begin
      case (rd_dec[1:0])
        RBT_IDX_CTRL:
        begin
          rd[RBT_CTRL_OE_N_BIT]   = st_r.ctrl.output_enable_n;
          rd[RBT_CTRL_DIR_BIT]    = st_r.ctrl.dir;
          rd[RBT_CTRL_AB_SEL_BIT] = st_r.ctrl.a_to_b_source_sel;
          rd[RBT_CTRL_BA_SEL_BIT] = st_r.ctrl.b_to_a_source_sel;
        end
        RBT_IDX_STORE:
        begin
          // Never-loaded storage reads as zero
          rd[RBT_STORE_A_LSB +: RBT_BUS_W] = st_r.a_store & {RBT_BUS_W{st_r.a_loaded}};
          rd[RBT_STORE_B_LSB +: RBT_BUS_W] = st_r.b_store & {RBT_BUS_W{st_r.b_loaded}};
          rd[RBT_STORE_A_VALID_BIT]        = st_r.a_loaded;
          rd[RBT_STORE_B_VALID_BIT]        = st_r.b_loaded;
        end
        RBT_IDX_LIVE:
        begin
          rd[RBT_LIVE_A_LSB +: RBT_BUS_W] = a_in;
          rd[RBT_LIVE_B_LSB +: RBT_BUS_W] = b_in;
          rd[RBT_LIVE_A_DRV_BIT]          = a_enabled;
          rd[RBT_LIVE_B_DRV_BIT]          = b_enabled;
        end
        RBT_IDX_LOG:
        begin
          if (log_valid)
          begin
            rd[RBT_LOG_A_LSB +: RBT_BUS_W] = log_out.a_data;
            rd[RBT_LOG_B_LSB +: RBT_BUS_W] = log_out.b_data;
            rd[RBT_LOG_A_CAP_BIT]          = log_out.a_cap;
            rd[RBT_LOG_B_CAP_BIT]          = log_out.b_cap;
          end
          rd[RBT_LOG_OVF_BIT]   = st_r.log_overflow;
          rd[RBT_LOG_VALID_BIT] = log_valid;
        end
        default:
        begin
          rd = '0;
        end
      endcase
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_dec[2] ? rd : '0;
      st_nxt.rresp  = rd_dec[2] ? RBT_RESP_OKAY : RBT_RESP_SLVERR;
    end
    else if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end

    // Synchronous reset leaves the storage registers untouched
    if (!aresetn)
    begin
      st_nxt.ctrl         = RBT_CTRL_RESET;
      st_nxt.a_loaded     = 1'b0;
      st_nxt.b_loaded     = 1'b0;
      // History starts high: a clock held high through reset is no capture
      st_nxt.a_clk_prev   = 1'b1;
      st_nxt.b_clk_prev   = 1'b1;
      st_nxt.log_overflow = 1'b0;
      st_nxt.aw_got       = 1'b0;
      st_nxt.w_got        = 1'b0;
      st_nxt.awaddr       = '0;
      st_nxt.wdata        = '0;
      st_nxt.wstrb        = '0;
      st_nxt.bvalid       = 1'b0;
      st_nxt.bresp        = RBT_RESP_OKAY;
      st_nxt.rvalid       = 1'b0;
      st_nxt.rdata        = '0;
      st_nxt.rresp        = RBT_RESP_OKAY;
    end
  end

  always_ff @(posedge aclk)
  begin
    st_r <= st_nxt;
  end

endmodule

// [verif/rbt_transceiver_sva.sv]
// Port-level checker for the registered bus transceiver.
// Assumes one clock and a synchronous active-low reset; bound from the bench.
module rbt_transceiver_sva
  import rbt_pkg::*;
(
  // Clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Buses
  input wire logic [RBT_BUS_W-1:0] a_in,
  input wire logic [RBT_BUS_W-1:0] b_in,
  input wire rbt_drive_t           a_drive,
  input wire rbt_drive_t           b_drive,
  // Capture side
  input wire logic                 a_side_capture_clock,
  input wire logic                 b_side_capture_clock,
  input wire logic                 capture_log_ready,
  // Register bus handshakes
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid
);
  logic                 a_prev_r;
  logic                 b_prev_r;
  logic [RBT_BUS_W-1:0] a_sh_r;
  logic [RBT_BUS_W-1:0] b_sh_r;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Shadow copies of the storage registers
  always_ff @(posedge aclk)
  begin
    a_prev_r <= aresetn ? a_side_capture_clock : 1'b1;
    b_prev_r <= aresetn ? b_side_capture_clock : 1'b1;
    if (aresetn && a_side_capture_clock && !a_prev_r) a_sh_r <= a_in;
    if (aresetn && b_side_capture_clock && !b_prev_r) b_sh_r <= b_in;
  end

  sequence aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence w_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  drive_excl_a: assert property (!(|a_drive.oe && |b_drive.oe))
    else $error("both buses driven");
  oe_uniform_a: assert property ((a_drive.oe == 8'h00 || a_drive.oe == 8'hFF)
    && (b_drive.oe == 8'h00 || b_drive.oe == 8'hFF))
    else $error("enable differs between bits");
  a_source_a: assert property (|a_drive.oe |->
    (a_drive.data == b_in || a_drive.data == b_sh_r))
    else $error("A bus data from wrong source");
  b_source_a: assert property (|b_drive.oe |->
    (b_drive.data == a_in || b_drive.data == a_sh_r))
    else $error("B bus data from wrong source");
  oe_timing_a: assert property ($changed(a_drive.oe) || $changed(b_drive.oe)
    |-> $rose(s_axi_bvalid))
    else $error("enable changed without a write");
  log_push_a: assert property ($fell(capture_log_ready) |->
    ($past(a_side_capture_clock) && !$past(a_side_capture_clock, 2))
    || ($past(b_side_capture_clock) && !$past(b_side_capture_clock, 2)))
    else $error("log filled without a capture");
  wr_answer_a: assert property ((aw_taken and w_taken) |=> s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read data late");
endmodule

// [verif/rbt_bus_model.sv]
// Far-side bus logic on both ports.
// Assumes the bench picks the values; the far side backs off where the device drives.
module rbt_bus_model
  import rbt_pkg::*;
(
  // Device drive
  input  wire rbt_drive_t           a_drive,
  input  wire rbt_drive_t           b_drive,
  // Far-side values
  input  wire logic [RBT_BUS_W-1:0] a_val,
  input  wire logic [RBT_BUS_W-1:0] b_val,
  // Resolved wires
  output logic [RBT_BUS_W-1:0]      a_in,
  output logic [RBT_BUS_W-1:0]      b_in
);
  timeunit 1ns;
  timeprecision 1ns;
  assign a_in = (a_drive.oe & a_drive.data) | (~a_drive.oe & a_val);
  assign b_in = (b_drive.oe & b_drive.data) | (~b_drive.oe & b_val);
endmodule

// [verif/rbt_transceiver_test.sv]
// Self-checking bench for the registered bus transceiver.
// Assumes the far-side model resolves both buses; one 10 MHz clock.
`define CHK(nm, ex, gt) \
  begin \
    samples_checked++; \
    if ((gt) !== (ex)) \
    begin \
      miscompares++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module rbt_transceiver_test
  import rbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  aclk = 1'b0;
  logic                  aresetn = 1'b0;
  logic                  a_side_capture_clock = 1'b0;
  logic                  b_side_capture_clock = 1'b0;
  logic [RBT_BUS_W-1:0]  a_val = 8'h00;
  logic [RBT_BUS_W-1:0]  b_val = 8'h00;
  logic [RBT_BUS_W-1:0]  a_in;
  logic [RBT_BUS_W-1:0]  b_in;
  rbt_drive_t            a_drive;
  rbt_drive_t            b_drive;
  logic                  capture_log_ready;
  logic                  s_axi_awvalid = 1'b0;
  logic                  s_axi_wvalid = 1'b0;
  logic                  s_axi_bready = 1'b0;
  logic                  s_axi_arvalid = 1'b0;
  logic                  s_axi_rready = 1'b0;
  logic                  s_axi_awready;
  logic                  s_axi_wready;
  logic                  s_axi_bvalid;
  logic                  s_axi_arready;
  logic                  s_axi_rvalid;
  logic [RBT_AXI_AW-1:0] s_axi_awaddr = 6'h00;
  logic [RBT_AXI_AW-1:0] s_axi_araddr = 6'h00;
  logic [31:0]           s_axi_wdata = 32'h0;
  logic [31:0]           s_axi_rdata;
  logic [1:0]            s_axi_bresp;
  logic [1:0]            s_axi_rresp;
  logic [31:0]           d;
  logic [1:0]            r;
  int                    miscompares = 0;
  int                    samples_checked = 0;
  int                    cycles = 0;

  rbt_transceiver rbt_transceiver_i (.aclk, .aresetn, .a_in, .a_drive, .b_in, .b_drive,
    .a_side_capture_clock, .b_side_capture_clock, .capture_log_ready,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp);
  rbt_bus_model rbt_bus_model_i (.a_drive, .b_drive, .a_val, .b_val, .a_in, .b_in);

  always #50 aclk = ~aclk;

  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end

  task automatic wr(input logic [RBT_AXI_AW-1:0] ad, input logic [31:0] dt);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [RBT_AXI_AW-1:0] ad);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One capture pulse: high for one cycle, then low
  task automatic pulse(input logic pa, input logic pb);
    @(posedge aclk);
    a_side_capture_clock <= pa;
    b_side_capture_clock <= pb;
    @(posedge aclk);
    a_side_capture_clock <= 1'b0;
    b_side_capture_clock <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic t_reset;
    rd(RBT_ADDR_CTRL);
    `CHK("ctrl reset", 32'h1, d)
    `CHK("ctrl resp", RBT_RESP_OKAY, r)
    `CHK("a oe", 8'h00, a_drive.oe)
    `CHK("b oe", 8'h00, b_drive.oe)
    rd(RBT_ADDR_STORE);
    `CHK("store empty", 32'h0, d)
    rd(6'h10);
    `CHK("unmapped read", RBT_RESP_SLVERR, r)
    wr(6'h30, 32'h0);
    `CHK("unmapped write", RBT_RESP_SLVERR, r)
  endtask

  task automatic t_iso;
    a_val <= 8'h5A;
    b_val <= 8'hC3;
    pulse(1'b1, 1'b1);
    `CHK("iso a oe", 8'h00, a_drive.oe)
    rd(RBT_ADDR_STORE);
    `CHK("store both", 32'h3C35A, d)
    rd(RBT_ADDR_LOG);
    `CHK("log both", 32'h8003C35A, d)
  endtask

  task automatic t_modes;
    a_val <= 8'h11;
    b_val <= 8'h22;
    for (int i = 0; i < 8; i++)
    begin
      wr(RBT_ADDR_CTRL, {28'h0, i[2:0], 1'b0});
      #10;
      `CHK("a oe", i[0] ? 8'h00 : 8'hFF, a_drive.oe)
      `CHK("b oe", i[0] ? 8'hFF : 8'h00, b_drive.oe)
      if (i[0])
        `CHK("b data", i[1] ? 8'h5A : 8'h11, b_drive.data)
      else
        `CHK("a data", i[2] ? 8'hC3 : 8'h22, a_drive.data)
    end
  endtask

  // B bus shows the A-side register while A is captured; log overflows
  task automatic t_drive_log;
    a_val <= 8'h96;
    pulse(1'b1, 1'b0);
    `CHK("b stored", 8'h96, b_drive.data)
    rd(RBT_ADDR_STORE);
    `CHK("store a only", 32'h3C396, d)
    rd(RBT_ADDR_LIVE);
    `CHK("live", 32'h29696, d)
    for (int k = 0; k < 4; k++)
      pulse(1'b1, 1'b0);
    `CHK("log full", 1'b0, capture_log_ready)
    for (int k = 0; k < 4; k++)
    begin
      rd(RBT_ADDR_LOG);
      `CHK("log pop", 32'hC0010096, d & 32'hC00300FF)
    end
    wr(RBT_ADDR_LOG, 32'h40000000);
    rd(RBT_ADDR_LOG);
    `CHK("log clear", 32'h0, d)
  endtask

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_iso();
    t_modes();
    t_drive_log();
    end_sim();
  end
endmodule

bind rbt_transceiver rbt_transceiver_sva rbt_transceiver_sva_i (.aclk, .aresetn, .a_in, .b_in,
  .a_drive, .b_drive, .a_side_capture_clock, .b_side_capture_clock, .capture_log_ready,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
